/* File: verilog/twq_pkg.sv */
`default_nettype none
package twq_pkg;

  // ------------------------------------------------------------
  // Widths and constants
  // ------------------------------------------------------------
  localparam int SMP_W = 12;
  localparam int CNT_W = 24;
  localparam logic [CNT_W-1:0] CNT_MAX = 24'hFFFFFF;
  localparam logic [CNT_W-1:0] CNT_RST = 24'h000000;

  // ------------------------------------------------------------
  // Encodings
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    TWQ_T_WINDOW  = 2'h0,
    TWQ_T_TIMEOUT = 2'h1,
    TWQ_T_INTERV  = 2'h2,
    TWQ_T_SLEW    = 2'h3
  } twq_type_t;

  typedef enum logic [1:0] {
    TWQ_V_ENTER  = 2'h0,
    TWQ_V_EXIT   = 2'h1,
    TWQ_V_STAYIN = 2'h2,
    TWQ_V_STAYOUT = 2'h3
  } twq_vcond_t;

  typedef enum logic [1:0] {
    TWQ_R_WITHIN  = 2'h0,
    TWQ_R_OUTSIDE = 2'h1,
    TWQ_R_SHORTER = 2'h2,
    TWQ_R_LONGER  = 2'h3
  } twq_range_t;

  // Polarity: 0 positive/high, 1 negative/low, 2 either
  typedef enum logic [1:0] {
    TWQ_P_POS    = 2'h0,
    TWQ_P_NEG    = 2'h1,
    TWQ_P_EITHER = 2'h2
  } twq_pol_t;

  typedef enum logic [2:0] {
    TWQ_S_IDLE = 3'h1,
    TWQ_S_UP   = 3'h2,
    TWQ_S_DN   = 3'h4
  } twq_slew_st_t;

  // ------------------------------------------------------------
  // Carriers
  // ------------------------------------------------------------
  typedef struct packed {
    twq_type_t        trig_type;
    twq_vcond_t       vcond;
    twq_range_t       range;
    twq_pol_t         pol;
    logic [SMP_W-1:0] upper;
    logic [SMP_W-1:0] lower;
    logic [SMP_W-1:0] level;
    logic [CNT_W-1:0] width;
    logic [CNT_W-1:0] delta;
  } twq_cfg_t;

  typedef struct packed {
    logic above_up;
    logic below_lo;
    logic above_lvl;
  } twq_flags_t;

endpackage
`default_nettype wire

/* File: verilog/twq_flags.sv */
`timescale 1ns/1ps
`default_nettype none
module twq_flags (
  // Clock and reset
  input  wire logic                      ref_clk,
  input  wire logic                      rstn,
  // Sample and thresholds
  input  wire logic                      smp_valid,
  input  wire logic [twq_pkg::SMP_W-1:0] smp,
  input  wire logic [twq_pkg::SMP_W-1:0] upper,
  input  wire logic [twq_pkg::SMP_W-1:0] lower,
  input  wire logic [twq_pkg::SMP_W-1:0] level,
  // Registered flags
  output logic                           flg_valid,
  output var  twq_pkg::twq_flags_t       flg
);

  typedef struct packed {
    logic                valid;
    twq_pkg::twq_flags_t f;
  } twq_fst_t;

  twq_fst_t st_r;
  twq_fst_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.valid = smp_valid;
    if (smp_valid) begin
      st_nxt.f.above_up  = smp > upper;
      st_nxt.f.below_lo  = smp < lower;
      st_nxt.f.above_lvl = smp > level;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign flg_valid = st_r.valid;
  assign flg       = st_r.f;

endmodule
`default_nettype wire

/* File: verilog/twq_top.sv */
`timescale 1ns/1ps
`default_nettype none
module twq_top (
  // Clock and reset
  input  wire logic                      ref_clk,
  input  wire logic                      rstn,
  // Sample stream, same clock domain
  input  wire logic                      smp_valid,
  input  wire logic [twq_pkg::SMP_W-1:0] smp,
  // Configuration
  input  wire logic                      arm,
  input  var  twq_pkg::twq_cfg_t         cfg,
  // Trigger out
  output logic                           trig,
  output logic [twq_pkg::CNT_W-1:0]      meas
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    logic                        primed;
    logic                        prev_in;
    logic                        prev_hi;
    logic                        prev_lo;
    logic                        prev_lvl;
    logic                        have_edge;
    logic                        to_done;
    logic [twq_pkg::CNT_W-1:0]   cnt;
    twq_pkg::twq_slew_st_t       slew;
    logic                        trig;
    logic [twq_pkg::CNT_W-1:0]   meas;
  } twq_st_t;

  twq_st_t st_r;
  twq_st_t st_nxt;

  logic                flg_valid;
  twq_pkg::twq_flags_t flg;

  twq_flags u_flags (
    .ref_clk   (ref_clk),
    .rstn      (rstn),
    .smp_valid (smp_valid),
    .smp       (smp),
    .upper     (cfg.upper),
    .lower     (cfg.lower),
    .level     (cfg.level),
    .flg_valid (flg_valid),
    .flg       (flg)
  );

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  // Saturating increment so a stuck level never wraps to short
  function automatic logic [twq_pkg::CNT_W-1:0] inc_sat(
    input logic [twq_pkg::CNT_W-1:0] v);
    if (v == twq_pkg::CNT_MAX) begin
      inc_sat = v;
    end else begin
      inc_sat = v + 24'h000001;
    end
  endfunction

  // Duration check shared by dwell, interval and slew
  function automatic logic time_ok(
    input twq_pkg::twq_range_t       rng,
    input logic [twq_pkg::CNT_W-1:0] dur,
    input logic [twq_pkg::CNT_W-1:0] w,
    input logic [twq_pkg::CNT_W-1:0] d);
    logic [twq_pkg::CNT_W:0] lo;
    logic [twq_pkg::CNT_W:0] hi;
    logic                    in_band;
    // Lower bound clamps at zero when delta exceeds width; widened upper bound avoids wrap
    lo = (d > w) ? '0 : {1'b0, w - d};
    hi = {1'b0, w} + {1'b0, d};
    in_band = ({1'b0, dur} >= lo) && ({1'b0, dur} <= hi);
    unique case (rng)
      twq_pkg::TWQ_R_WITHIN:  time_ok = in_band;
      twq_pkg::TWQ_R_OUTSIDE: time_ok = !in_band;
      twq_pkg::TWQ_R_SHORTER: time_ok = dur < w;
      twq_pkg::TWQ_R_LONGER:  time_ok = dur > w;
    endcase
  endfunction

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  logic in_win;
  logic rise;
  logic fall;
  logic edge_sel;
  logic to_watch;

  always_comb begin
    st_nxt   = st_r;
    st_nxt.trig = 1'b0;
    in_win   = !flg.above_up && !flg.below_lo;
    rise     = flg.above_lvl && !st_r.prev_lvl;
    fall     = !flg.above_lvl && st_r.prev_lvl;
    edge_sel = 1'b0;
    to_watch = 1'b0;
    unique case (cfg.pol)
      twq_pkg::TWQ_P_POS: begin
        edge_sel = rise;
        to_watch = flg.above_lvl;
      end
      twq_pkg::TWQ_P_NEG: begin
        edge_sel = fall;
        to_watch = !flg.above_lvl;
      end
      default: begin
        edge_sel = rise || fall;
        to_watch = 1'b1;
      end
    endcase

    if (!arm) begin
      st_nxt.primed    = 1'b0;
      st_nxt.have_edge = 1'b0;
      st_nxt.to_done   = 1'b0;
      st_nxt.cnt       = twq_pkg::CNT_RST;
      st_nxt.slew      = twq_pkg::TWQ_S_IDLE;
    end else if (flg_valid) begin
      st_nxt.primed   = 1'b1;
      st_nxt.prev_in  = in_win;
      st_nxt.prev_hi  = flg.above_up;
      st_nxt.prev_lo  = flg.below_lo;
      st_nxt.prev_lvl = flg.above_lvl;
      st_nxt.cnt      = inc_sat(st_r.cnt);
      unique case (cfg.trig_type)
        twq_pkg::TWQ_T_WINDOW: begin
          if (st_r.primed && (in_win != st_r.prev_in)) begin
            // Dwell ends on any crossing; one begun before arming
            // has no known start and is never judged
            st_nxt.cnt       = twq_pkg::CNT_RST;
            st_nxt.meas      = st_r.cnt;
            st_nxt.have_edge = 1'b1;
            unique case (cfg.vcond)
              twq_pkg::TWQ_V_ENTER:
                st_nxt.trig = in_win;
              twq_pkg::TWQ_V_EXIT:
                st_nxt.trig = !in_win;
              twq_pkg::TWQ_V_STAYIN:
                st_nxt.trig = st_r.have_edge && st_r.prev_in &&
                  time_ok(cfg.range, st_r.cnt, cfg.width, cfg.delta);
              twq_pkg::TWQ_V_STAYOUT:
                st_nxt.trig = st_r.have_edge && !st_r.prev_in &&
                  time_ok(cfg.range, st_r.cnt, cfg.width, cfg.delta);
            endcase
          end else if (st_r.primed && !in_win &&
                       (flg.above_up != st_r.prev_hi)) begin
            // Jump across the band: ends one outside dwell and starts a fresh one
            st_nxt.cnt       = twq_pkg::CNT_RST;
            st_nxt.meas      = st_r.cnt;
            st_nxt.have_edge = 1'b1;
            if (st_r.have_edge &&
                (cfg.vcond == twq_pkg::TWQ_V_STAYOUT)) begin
              st_nxt.trig = time_ok(cfg.range, st_r.cnt,
                                    cfg.width, cfg.delta);
            end
          end else if (!st_r.primed) begin
            st_nxt.cnt = twq_pkg::CNT_RST;
          end
        end
        twq_pkg::TWQ_T_TIMEOUT: begin
          if (!st_r.primed || rise || fall) begin
            st_nxt.cnt     = twq_pkg::CNT_RST;
            st_nxt.to_done = 1'b0;
          end else if (to_watch && !st_r.to_done &&
                       (st_r.cnt >= cfg.width)) begin
            // One trigger per stuck period
            st_nxt.trig    = 1'b1;
            st_nxt.to_done = 1'b1;
            st_nxt.meas    = st_r.cnt;
          end
        end
        twq_pkg::TWQ_T_INTERV: begin
          if (st_r.primed && edge_sel) begin
            st_nxt.cnt       = twq_pkg::CNT_RST;
            st_nxt.have_edge = 1'b1;
            st_nxt.meas      = st_r.cnt;
            // First edge only opens the measurement
            st_nxt.trig = st_r.have_edge &&
              time_ok(cfg.range, st_r.cnt, cfg.width, cfg.delta);
          end
        end
        default: begin
          unique case (st_r.slew)
            twq_pkg::TWQ_S_IDLE: begin
              st_nxt.cnt = twq_pkg::CNT_RST;
              // Leaving a limit toward the other starts the timer
              if (st_r.primed && st_r.prev_lo && !flg.below_lo &&
                  (cfg.pol != twq_pkg::TWQ_P_NEG)) begin
                st_nxt.slew = twq_pkg::TWQ_S_UP;
              end else if (st_r.primed && st_r.prev_hi &&
                           !flg.above_up &&
                           (cfg.pol != twq_pkg::TWQ_P_POS)) begin
                st_nxt.slew = twq_pkg::TWQ_S_DN;
              end
            end
            twq_pkg::TWQ_S_UP: begin
              if (flg.above_up) begin
                st_nxt.slew = twq_pkg::TWQ_S_IDLE;
                st_nxt.meas = st_r.cnt;
                st_nxt.trig = time_ok(cfg.range,
                  st_r.cnt, cfg.width, cfg.delta);
              end else if (flg.below_lo) begin
                st_nxt.slew = twq_pkg::TWQ_S_IDLE;
              end
            end
            twq_pkg::TWQ_S_DN: begin
              if (flg.below_lo) begin
                st_nxt.slew = twq_pkg::TWQ_S_IDLE;
                st_nxt.meas = st_r.cnt;
                st_nxt.trig = time_ok(cfg.range,
                  st_r.cnt, cfg.width, cfg.delta);
              end else if (flg.above_up) begin
                st_nxt.slew = twq_pkg::TWQ_S_IDLE;
              end
            end
            default: begin
              st_nxt.slew = twq_pkg::TWQ_S_IDLE;
            end
          endcase
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      st_r      <= '0;
      st_r.slew <= twq_pkg::TWQ_S_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign trig = st_r.trig;
  assign meas = st_r.meas;

endmodule
`default_nettype wire

/* File: tb/twq_top_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module twq_top_asserts (
  // Clock and reset
  input wire logic                      ref_clk,
  input wire logic                      rstn,
  // Samples and control
  input wire logic                      smp_valid,
  input wire logic [twq_pkg::SMP_W-1:0] smp,
  input wire logic                      arm,
  input var  twq_pkg::twq_cfg_t         cfg,
  // Trigger out
  input wire logic                      trig,
  input wire logic [twq_pkg::CNT_W-1:0] meas
);
  logic au, bl, al, ins, pos, wen, wex, slw, edg;
  assign au  = smp > cfg.upper;
  assign bl  = smp < cfg.lower;
  assign al  = smp > cfg.level;
  assign ins = !au && !bl;
  assign pos = cfg.pol == twq_pkg::TWQ_P_POS;
  assign wen = cfg.trig_type == twq_pkg::TWQ_T_WINDOW
             && cfg.vcond == twq_pkg::TWQ_V_ENTER;
  assign wex = cfg.trig_type == twq_pkg::TWQ_T_WINDOW
             && cfg.vcond == twq_pkg::TWQ_V_EXIT;
  assign slw = cfg.trig_type == twq_pkg::TWQ_T_SLEW
             && cfg.pol != twq_pkg::TWQ_P_EITHER;
  assign edg = (cfg.trig_type == twq_pkg::TWQ_T_INTERV
             || cfg.trig_type == twq_pkg::TWQ_T_TIMEOUT)
             && cfg.pol != twq_pkg::TWQ_P_EITHER;
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  sequence s_take(bit want);
    arm && smp_valid && ins == want;
  endsequence
  enter_fire_a:
    assert property (wen ##0 s_take(1'b0) ##1 s_take(1'b1) ##1 arm [*2]
      |-> trig) else $error("window entry not fired");
  exit_fire_a:
    assert property (wex ##0 s_take(1'b1) ##1 s_take(1'b0) ##1 arm [*2]
      |-> trig) else $error("window exit not fired");
  trig_cause_a:
    assert property (trig |-> $past(smp_valid, 2))
      else $error("trigger without a sample");
  meas_cause_a:
    assert property ($changed(meas) |-> $past(smp_valid, 2))
      else $error("duration moved without a sample");
  arm_quiet_a:
    assert property (!arm [*3] |-> !trig)
      else $error("trigger while disarmed");
  arm_prime_a:
    assert property ($rose(arm) |-> !trig ##1 !trig)
      else $error("trigger right after arming");
  slew_dir_a:
    assert property (trig && slw |-> (pos ? $past(au, 2) : $past(bl, 2)))
      else $error("slew trigger on wrong direction");
  edge_side_a:
    assert property (trig && edg |-> $past(al, 2) == pos)
      else $error("trigger on wrong side of level");
endmodule
bind twq_top twq_top_asserts u_chk (
  .ref_clk(ref_clk), .rstn(rstn), .smp_valid(smp_valid), .smp(smp),
  .arm(arm), .cfg(cfg), .trig(trig), .meas(meas));
`default_nettype wire

/* File: tb/twq_src.sv */
`timescale 1ns/1ps
`default_nettype none
module twq_src (
  // Clock
  input  wire logic                      ref_clk,
  // Requests from the bench
  input  wire logic                      rq_valid,
  input  wire logic [twq_pkg::SMP_W-1:0] rq_smp,
  // Sample stream
  output logic                           smp_valid,
  output logic [twq_pkg::SMP_W-1:0]      smp
);
  logic [twq_pkg::SMP_W-1:0] last_r = 12'h000;
  always_ff @(posedge ref_clk) begin
    if (rq_valid) begin
      last_r <= rq_smp;
    end
  end
  // Idle samples show the inverse, so a stale read cannot pass
  assign smp_valid = rq_valid;
  assign smp       = rq_valid ? rq_smp : ~last_r;
endmodule
`default_nettype wire

/* File: tb/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic                      ref_clk = 1'b0;
  logic                      rstn = 1'b0;
  logic                      arm = 1'b0;
  logic                      rq_valid = 1'b0;
  logic [twq_pkg::SMP_W-1:0] rq_smp = 12'h000;
  logic                      smp_valid, trig;
  logic [twq_pkg::SMP_W-1:0] smp;
  logic [twq_pkg::CNT_W-1:0] meas;
  logic [twq_pkg::CNT_W-1:0] mp [2];
  logic [1:0]                tp, vp;
  twq_pkg::twq_cfg_t         cfg;
  int                        mismatches = 0;
  int                        checked = 0;
  int unsigned               seed = 92628;
  int                        cnt, mdl, pg, ss;
  bit                        pa, pb, pl, pr, he, fd;
  always #20 ref_clk = ~ref_clk;
  twq_src u_src (.ref_clk(ref_clk), .rq_valid(rq_valid), .rq_smp(rq_smp),
    .smp_valid(smp_valid), .smp(smp));
  twq_top u_dut (.ref_clk(ref_clk), .rstn(rstn), .smp_valid(smp_valid),
    .smp(smp), .arm(arm), .cfg(cfg), .trig(trig), .meas(meas));
  function automatic int unsigned rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic bit rc(int d);
    int w;
    bit ok;
    w  = int'(cfg.width);
    ok = d >= (w > int'(cfg.delta) ? w - int'(cfg.delta) : 0)
         && d <= w + int'(cfg.delta);
    case (cfg.range)
      twq_pkg::TWQ_R_WITHIN:  return ok;
      twq_pkg::TWQ_R_OUTSIDE: return !ok;
      twq_pkg::TWQ_R_SHORTER: return d < w;
      default:                return d > w;
    endcase
  endfunction
  // ------------------------------------------------------------
  // Reference model, one step per taken sample
  // ------------------------------------------------------------
  always @(posedge ref_clk) begin : mdl_step
    bit a, b, l, i, f, v, wp;
    int d;
    f = 1'b0;
    v = 1'b0;
    if (!rstn || !arm) pr = 1'b0;
    else if (smp_valid) begin
      a = smp > cfg.upper;
      b = smp < cfg.lower;
      l = smp > cfg.level;
      i = !a && !b;
      wp = cfg.pol == twq_pkg::TWQ_P_EITHER || l == (cfg.pol == 2'h0);
      d = cnt;
      cnt = cnt < 32'hFFFFFF ? cnt + 1 : cnt;
      if (!pr) begin
        pr = 1'b1;
        cnt = 0;
        he = 1'b0;
        fd = 1'b0;
        ss = 0;
      end else case (cfg.trig_type)
        twq_pkg::TWQ_T_WINDOW: if (i != (!pa && !pb)) begin
          if (cfg.vcond == twq_pkg::TWQ_V_ENTER) f = i;
          else if (cfg.vcond == twq_pkg::TWQ_V_EXIT) f = !i;
          else if (he && (cfg.vcond == twq_pkg::TWQ_V_STAYIN) == !i) begin
            v = 1'b1;
            f = rc(d);
          end
          cnt = 0;
          he = 1'b1;
        end else if (!i && a != pa) begin
          // Jump over the band ends an outside dwell only
          v = he && cfg.vcond == twq_pkg::TWQ_V_STAYOUT;
          f = v && rc(d);
          cnt = 0;
          he = 1'b1;
        end
        twq_pkg::TWQ_T_TIMEOUT: if (l != pl) begin
          cnt = 0;
          fd = 1'b0;
        end else if (!fd && wp && d >= int'(cfg.width)) begin
          f = 1'b1;
          fd = 1'b1;
          v = 1'b1;
        end
        twq_pkg::TWQ_T_INTERV: if (l != pl && wp) begin
          v = he;
          f = he && rc(d);
          cnt = 0;
          he = 1'b1;
        end
        default: begin
          if (ss != 0 && (a || b)) begin
            v = (ss == 1) == a;
            f = v && rc(d);
            ss = 0;
          end
          if (pb && !b && cfg.pol != twq_pkg::TWQ_P_NEG) begin
            ss = 1;
            cnt = 0;
          end
          if (pa && !a && cfg.pol != twq_pkg::TWQ_P_POS) begin
            ss = 2;
            cnt = 0;
          end
        end
      endcase
      if (v) mdl = d;
      pa = a;
      pb = b;
      pl = l;
    end
    tp <= {tp[0], f};
    vp <= {vp[0], v};
    mp <= '{24'(mdl), mp[0]};
  end
  task automatic chk(logic [23:0] g, logic [23:0] e);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  always @(negedge ref_clk) begin
    if (rstn) begin
      chk({23'h0, trig}, {23'h0, tp[1]});
      if (vp[1]) chk(meas, mp[1]);
    end
  end
  task automatic put(int g);
    @(negedge ref_clk);
    if (rnd() % 4 == 0) begin
      rq_valid = 1'b0;
      @(negedge ref_clk);
    end
    rq_valid = 1'b1;
    rq_smp = g == 0 ? 12'(rnd() % 32'h400) : g == 1
           ? 12'(32'h400 + rnd() % 32'h801) : 12'(32'hC01 + rnd() % 32'h3FF);
  endtask
  task automatic run(int t, int c, int r);
    int g;
    @(negedge ref_clk);
    cfg.trig_type = twq_pkg::twq_type_t'(t[1:0]);
    cfg.vcond = twq_pkg::twq_vcond_t'(c[1:0]);
    cfg.pol = twq_pkg::twq_pol_t'(c == 3 ? 2'h0 : c[1:0]);
    cfg.range = twq_pkg::twq_range_t'(r[1:0]);
    cfg.width = 24'(2 + rnd() % 8);
    cfg.delta = 24'(rnd() % 3);
    arm = 1'b1;
    pg = 1;
    // Jumps over the band only in window mode; elsewhere they skip timing
    repeat (20) begin
      g = int'(rnd() % 3);
      if (t != 0 && g != 1 && pg != 1 && g != pg) g = 1;
      pg = g;
      repeat (1 + rnd() % 10) put(g);
    end
    @(negedge ref_clk);
    rq_valid = 1'b0;
    repeat (4) @(negedge ref_clk);
    arm = 1'b0;
    // Samples while disarmed must be ignored
    repeat (3) put(int'(rnd() % 3));
    @(negedge ref_clk);
    rq_valid = 1'b0;
    $display("test type %0d cond %0d range %0d done", t, c, r);
  endtask
  task automatic final_report();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge ref_clk);
    mismatches++;
    final_report();
  end
  initial begin
    cfg = '0;
    cfg.upper = 12'hC00;
    cfg.lower = 12'h400;
    cfg.level = 12'h800;
    repeat (6) @(negedge ref_clk);
    rstn = 1'b1;
    for (int t = 0; t < 4; t++)
      for (int c = 0; c < 4; c++)
        for (int r = 0; r < 4; r++)
          if (t == 0 || c < 3) run(t, c, r);
    final_report();
  end
endmodule
`default_nettype wire
